/* rcbs_pkg.sv */
// constants, field layouts and types of the reference clock buffer select block
package rcbs_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SIM = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] ROW_SEL_CLOCK = 2'h0;
  localparam logic [1:0] ROW_SEL_DIV2 = 2'h1;
  localparam logic [1:0] ROW_SEL_ZERO = 2'h2;

  localparam logic [1:0] SIM_ACCEL_TRUE = 2'h0;
  localparam logic [1:0] SIM_ACCEL_FALSE = 2'h1;
  localparam logic [1:0] SIM_ACCEL_FAST_ALIGN = 2'h2;

  localparam logic [7:0] CTRL_RESET = 8'h03;
  localparam logic [7:0] SIM_RESET = 8'h00;
  localparam int SIM_RX_DET_START_BIT = 3;

  localparam logic [8:0] RESET_SEQ_APPROX = 9'h010;
  localparam logic [8:0] RESET_SEQ_DETAILED = 9'h100;
  localparam logic [8:0] RESET_SEQ_FAST_ALIGN = 9'h008;
  localparam logic [3:0] RX_DET_CYCLES = 4'h4;

  localparam int ST_OUTPUT_MODE = 0;
  localparam int ST_BUFFERED_CLOCK = 1;
  localparam int ST_ROW_CLOCK = 2;
  localparam int ST_RESET_SEQ_DONE = 3;
  localparam int ST_RX_DET_DONE = 4;
  localparam int ST_RX_DET_PASS = 5;
  localparam int ST_CHANNEL_LO = 6;
  localparam int ST_CHANNEL_HI = 7;
  localparam int ST_TX_PATH_ERR = 8;

  typedef struct packed {
    logic [2:0] unused;
    logic txPathEnableCfg;
    logic [1:0] rowClockSelect;
    logic outBufEnN;
    logic inBufEnN;
  } rcbs_ctrl_t;

  typedef struct packed {
    logic [4:0] unused;
    logic simRxDetectResult;
    logic [1:0] simResetAcceleration;
  } rcbs_sim_t;

  typedef enum logic [1:0] {DET_IDLE, DET_BUSY, DET_DONE} rcbs_det_state_t;
endpackage : rcbs_pkg

/* rcbs_sync.sv */
// two flip-flop synchroniser bank for asynchronous inputs
`timescale 1ns/1ps
module rcbs_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic [WIDTH-1:0] asyncIn, // inputs from outside the clock domain
  output logic [WIDTH-1:0] syncOut // synchronised copies
);
  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          stage1[i] <= 1'b0;
          syncOut[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= asyncIn[i];
          syncOut[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule : rcbs_sync

/* rcbs_ref_clock_buffer_select.sv */
// reference clock input/output buffer logic with an axi4-lite register slave
// Overview of operation
// - input buffer passes pad clock only when enabled
// - buffered clock feeds quad and channel plls
// - row clock carries buffered or halved clock
// - select 00 clock, 01 half, 10 zero
// - pin direction fixed at build, both pins inputs during reset
// - output mode routes any quad channel clock
// - fixed output forwards one channel, power down
// - reset sequence length follows acceleration setting
// - receiver detect reports configured pass or fail
// - two-bit select from common unit picks channel
`timescale 1ns/1ps
module rcbs_ref_clock_buffer_select #(
  parameter bit OUTPUT_MODE = 1'b0, // 0 pins are inputs, 1 pins drive a recovered clock
  parameter bit SELECTABLE = 1'b0, // 1 runtime channel choice from the common unit
  parameter logic [1:0] FIXED_CHANNEL = 2'h0 // channel forwarded by the fixed variant
) (
  input wire logic clk, // 25 mhz system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [rcbs_pkg::ADDR_W-1:0] awaddr, // write byte address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [rcbs_pkg::ADDR_W-1:0] araddr, // read byte address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  input wire logic refClockPinPosIn, // positive reference clock pin level
  output logic refClockPinPosOut, // positive reference clock pin drive
  output logic refClockPinPosOeN, // positive pin output enable, low drives
  input wire logic refClockPinNegIn, // negative reference clock pin level
  output logic refClockPinNegOut, // negative reference clock pin drive
  output logic refClockPinNegOeN, // negative pin output enable, low drives
  input wire logic [3:0] recoveredRxClock, // recovered clocks of the four channels
  input wire logic [1:0] recoveredClockChannelSelect, // channel choice from the common unit
  output logic pllRefClock, // buffered clock to the quad and channel plls
  output logic rowClockOut // row clock towards the global clock buffer
);
  rcbs_pkg::rcbs_ctrl_t ctrl, next_ctrl;
  rcbs_pkg::rcbs_sim_t sim, next_sim;
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [rcbs_pkg::ADDR_W-1:0] awAddrHeld, next_awAddrHeld;
  logic [31:0] wDataHeld, next_wDataHeld;
  logic [3:0] wStrbHeld, next_wStrbHeld;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic simWrite, next_simWrite, detStart, next_detStart;

  logic [7:0] syncIn, syncOut;
  logic padPos, padNeg;
  logic [3:0] recSync;
  logic [1:0] selSync;
  logic next_pllRefClock, prevBuffered, next_prevBuffered, half, next_half, next_rowClockOut;
  logic next_pinPos, next_pinNeg;
  logic [1:0] activeChannel;
  logic [8:0] seqCount, next_seqCount;
  logic [3:0] detCount, next_detCount;
  rcbs_pkg::rcbs_det_state_t detState, next_detState;
  logic detPass, next_detPass;
  logic [31:0] status;

  assign syncIn = {recoveredClockChannelSelect, recoveredRxClock, refClockPinNegIn, refClockPinPosIn};

  rcbs_sync #(.WIDTH(8)) u_sync (
    .clk(clk),
    .reset(reset),
    .asyncIn(syncIn),
    .syncOut(syncOut)
  );

  assign padPos = syncOut[0];
  assign padNeg = syncOut[1];
  assign recSync = syncOut[5:2];
  assign selSync = syncOut[7:6];
  assign activeChannel = SELECTABLE ? selSync : FIXED_CHANNEL;

  always_comb
  begin
    status = 32'h0;
    status[rcbs_pkg::ST_OUTPUT_MODE] = OUTPUT_MODE;
    status[rcbs_pkg::ST_BUFFERED_CLOCK] = pllRefClock;
    status[rcbs_pkg::ST_ROW_CLOCK] = rowClockOut;
    status[rcbs_pkg::ST_RESET_SEQ_DONE] = (seqCount == 9'h000);
    status[rcbs_pkg::ST_RX_DET_DONE] = (detState == rcbs_pkg::DET_DONE);
    status[rcbs_pkg::ST_RX_DET_PASS] = detPass;
    status[rcbs_pkg::ST_CHANNEL_HI:rcbs_pkg::ST_CHANNEL_LO] = activeChannel;
    status[rcbs_pkg::ST_TX_PATH_ERR] = ctrl.txPathEnableCfg;
  end

  // register slave: address and data taken in either order, response after both
  always_comb
  begin
    next_ctrl = ctrl;
    next_sim = sim;
    next_awHeld = awHeld;
    next_awAddrHeld = awAddrHeld;
    next_wHeld = wHeld;
    next_wDataHeld = wDataHeld;
    next_wStrbHeld = wStrbHeld;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_simWrite = 1'b0;
    next_detStart = 1'b0;
    if (awvalid && awready)
    begin
      next_awHeld = 1'b1;
      next_awAddrHeld = awaddr;
    end
    if (wvalid && wready)
    begin
      next_wHeld = 1'b1;
      next_wDataHeld = wdata;
      next_wStrbHeld = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (awHeld && wHeld && !bvalid)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = rcbs_pkg::RESP_OKAY;
      case (awAddrHeld)
        rcbs_pkg::ADDR_CTRL:
          if (wStrbHeld[0])
          begin
            next_ctrl = rcbs_pkg::rcbs_ctrl_t'(wDataHeld[7:0]);
            next_ctrl.unused = 3'h0;
          end
        rcbs_pkg::ADDR_SIM:
          if (wStrbHeld[0])
          begin
            next_sim = rcbs_pkg::rcbs_sim_t'(wDataHeld[7:0]);
            next_sim.unused = 5'h00;
            next_simWrite = 1'b1;
            next_detStart = wDataHeld[rcbs_pkg::SIM_RX_DET_START_BIT];
          end
        rcbs_pkg::ADDR_STATUS: next_bresp = rcbs_pkg::RESP_OKAY;
        default: next_bresp = rcbs_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = rcbs_pkg::RESP_OKAY;
      case (araddr)
        rcbs_pkg::ADDR_CTRL: next_rdata = {24'h000000, ctrl};
        rcbs_pkg::ADDR_SIM: next_rdata = {24'h000000, sim};
        rcbs_pkg::ADDR_STATUS: next_rdata = status;
        default:
        begin
          next_rdata = 32'h0;
          next_rresp = rcbs_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_awHeld && !next_bvalid;
    next_wready = !next_wHeld && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl <= rcbs_pkg::rcbs_ctrl_t'(rcbs_pkg::CTRL_RESET);
      sim <= rcbs_pkg::rcbs_sim_t'(rcbs_pkg::SIM_RESET);
      awHeld <= 1'b0;
      awAddrHeld <= '0;
      wHeld <= 1'b0;
      wDataHeld <= 32'h0;
      wStrbHeld <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
      simWrite <= 1'b0;
      detStart <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      sim <= next_sim;
      awHeld <= next_awHeld;
      awAddrHeld <= next_awAddrHeld;
      wHeld <= next_wHeld;
      wDataHeld <= next_wDataHeld;
      wStrbHeld <= next_wStrbHeld;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      simWrite <= next_simWrite;
      detStart <= next_detStart;
    end
  end

  // clock path; pin direction is a build parameter, and both pins are inputs while reset is held
  always_comb
  begin
    next_pllRefClock = 1'b0;
    next_prevBuffered = 1'b0;
    next_half = 1'b0;
    next_rowClockOut = 1'b0;
    next_pinPos = 1'b0;
    next_pinNeg = 1'b0;
    if (!OUTPUT_MODE)
    begin
      if (!ctrl.inBufEnN)
      begin
        // a pin pair at equal levels carries no edge, so the last level holds
        next_pllRefClock = (padPos != padNeg) ? padPos : pllRefClock;
        next_prevBuffered = pllRefClock;
        next_half = (pllRefClock && !prevBuffered) ? !half : half;
      end
      case (ctrl.rowClockSelect)
        rcbs_pkg::ROW_SEL_CLOCK: next_rowClockOut = pllRefClock;
        rcbs_pkg::ROW_SEL_DIV2: next_rowClockOut = half;
        rcbs_pkg::ROW_SEL_ZERO: next_rowClockOut = 1'b0;
        default: next_rowClockOut = 1'b0;
      endcase
    end
    else if (!ctrl.outBufEnN)
    begin
      next_pinPos = recSync[activeChannel];
      next_pinNeg = !recSync[activeChannel];
    end
  end

  // simulation-model behaviour: reset sequence length and receiver detect answer
  always_comb
  begin
    next_seqCount = seqCount;
    next_detState = detState;
    next_detCount = detCount;
    next_detPass = detPass;
    if (simWrite)
    begin
      case (sim.simResetAcceleration)
        rcbs_pkg::SIM_ACCEL_TRUE: next_seqCount = rcbs_pkg::RESET_SEQ_APPROX;
        rcbs_pkg::SIM_ACCEL_FALSE: next_seqCount = rcbs_pkg::RESET_SEQ_DETAILED;
        rcbs_pkg::SIM_ACCEL_FAST_ALIGN: next_seqCount = rcbs_pkg::RESET_SEQ_FAST_ALIGN;
        default: next_seqCount = rcbs_pkg::RESET_SEQ_APPROX;
      endcase
    end
    else if (seqCount != 9'h000)
      next_seqCount = seqCount - 9'h001;
    case (detState)
      rcbs_pkg::DET_IDLE, rcbs_pkg::DET_DONE:
        if (detStart)
        begin
          next_detState = rcbs_pkg::DET_BUSY;
          next_detCount = rcbs_pkg::RX_DET_CYCLES;
          next_detPass = 1'b0;
        end
      rcbs_pkg::DET_BUSY:
        if (detCount == 4'h1)
        begin
          next_detState = rcbs_pkg::DET_DONE;
          next_detPass = sim.simRxDetectResult;
        end
        else
          next_detCount = detCount - 4'h1;
      default: next_detState = rcbs_pkg::DET_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pllRefClock <= 1'b0;
      prevBuffered <= 1'b0;
      half <= 1'b0;
      rowClockOut <= 1'b0;
      refClockPinPosOut <= 1'b0;
      refClockPinNegOut <= 1'b0;
      refClockPinPosOeN <= 1'b1;
      refClockPinNegOeN <= 1'b1;
      seqCount <= rcbs_pkg::RESET_SEQ_APPROX;
      detState <= rcbs_pkg::DET_IDLE;
      detCount <= 4'h0;
      detPass <= 1'b0;
    end
    else
    begin
      pllRefClock <= next_pllRefClock;
      prevBuffered <= next_prevBuffered;
      half <= next_half;
      rowClockOut <= next_rowClockOut;
      refClockPinPosOut <= next_pinPos;
      refClockPinNegOut <= next_pinNeg;
      refClockPinPosOeN <= !OUTPUT_MODE;
      refClockPinNegOeN <= !OUTPUT_MODE;
      seqCount <= next_seqCount;
      detState <= next_detState;
      detCount <= next_detCount;
      detPass <= next_detPass;
    end
  end
endmodule : rcbs_ref_clock_buffer_select

/* rcbs_clock_source.sv */
// free running clock source for the pads and the channel recovered clocks
`timescale 1ns/1ps
module rcbs_clock_source (
  input wire logic clk, // bench clock
  output logic padPos, // pad clock, positive leg
  output logic padNeg, // pad clock, negative leg
  output logic [3:0] recClk, // channel recovered clocks
  output logic [1:0] chanSel // common unit channel choice
);
  logic [7:0] cnt = 8'h00;
  always_ff @(posedge clk) cnt <= cnt + 8'h01;
  // pad period of eight bench cycles, legs always opposite
  assign padPos = cnt[2];
  assign padNeg = ~cnt[2];
  assign recClk = cnt[4:1];
  assign chanSel = cnt[7:6];
endmodule : rcbs_clock_source

/* rcbs_ref_clock_buffer_select_sva.sv */
// assertion checker for the reference clock buffer select block
`timescale 1ns/1ps
module rcbs_ref_clock_buffer_select_sva #(
  parameter bit OUTPUT_MODE = 1'h0
) (
  input wire logic clk, // clock
  input wire logic reset, // reset
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic [31:0] rdata, // r data
  input wire logic refClockPinPosIn, // pad level
  input wire logic refClockPinPosOut, // pos drive
  input wire logic refClockPinNegOut, // neg drive
  input wire logic refClockPinPosOeN, // pos enable
  input wire logic pllRefClock, // pll clock
  input wire logic rowClockOut // row clock
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_resp_late;
    !bvalid ##1 bvalid;
  endsequence
  property p_oe_fixed;
    !$past(reset) |-> refClockPinPosOeN == !OUTPUT_MODE;
  endproperty
  a_oe_fixed: assert property (p_oe_fixed) else $error("pin direction wrong");
  property p_no_drive;
    !OUTPUT_MODE |-> !refClockPinPosOut && !refClockPinNegOut;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("input pins driven");
  property p_diff;
    !(refClockPinPosOut && refClockPinNegOut);
  endproperty
  a_diff: assert property (p_diff) else $error("both legs high");
  property p_pll_src;
    $rose(pllRefClock) |-> $past(refClockPinPosIn, 3);
  endproperty
  a_pll_src: assert property (p_pll_src) else $error("pll clock rose without pad");
  property p_row_src;
    $rose(rowClockOut) |-> $past(pllRefClock) || $past(pllRefClock, 2) || $past(pllRefClock, 3);
  endproperty
  a_row_src: assert property (p_row_src) else $error("row clock rose alone");
  property p_wr_resp;
    s_wr_taken |=> s_resp_late;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_b_hold;
    bvalid && !bready |=> bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_taken;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_taken: assert property (p_r_taken) else $error("read data late");
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("ar taken while busy");
endmodule : rcbs_ref_clock_buffer_select_sva
bind rcbs_ref_clock_buffer_select rcbs_ref_clock_buffer_select_sva #(.OUTPUT_MODE(OUTPUT_MODE)) sva_inst (
  .clk(clk), .reset(reset), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .refClockPinPosIn(refClockPinPosIn), .refClockPinPosOut(refClockPinPosOut),
  .refClockPinNegOut(refClockPinNegOut), .refClockPinPosOeN(refClockPinPosOeN),
  .pllRefClock(pllRefClock), .rowClockOut(rowClockOut));

/* tb_ref_clock_buffer_select.sv */
// self-checking testbench of the reference clock buffer select block
`timescale 1ns/1ps
module tb_ref_clock_buffer_select;
  logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb, recClk;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, chSel;
  logic posIn, negIn, posOut, negOut, posOeN, negOeN, pllRefClock, rowClockOut;
  logic selPosOut, selNegOut, selPosOeN, selNegOeN, fixPosOut, fixNegOut, fixPosOeN, fixNegOeN;
  int fails = 0;
  int checksDone = 0;
  int cyc = 0;
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  rcbs_clock_source rcbs_clock_source_inst (.clk(clk), .padPos(posIn), .padNeg(negIn), .recClk(recClk),
    .chanSel(chSel));
  rcbs_ref_clock_buffer_select rcbs_ref_clock_buffer_select_inst (.clk(clk), .reset(reset),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .refClockPinPosIn(posIn), .refClockPinPosOut(posOut), .refClockPinPosOeN(posOeN),
    .refClockPinNegIn(negIn), .refClockPinNegOut(negOut), .refClockPinNegOeN(negOeN),
    .recoveredRxClock(recClk), .recoveredClockChannelSelect(chSel), .pllRefClock(pllRefClock),
    .rowClockOut(rowClockOut));
  // output-mode copies on the same bus: one with a runtime channel choice, one fixed on channel 2
  rcbs_ref_clock_buffer_select #(.OUTPUT_MODE(1'h1), .SELECTABLE(1'h1), .FIXED_CHANNEL(2'h0))
    rcbs_ref_clock_buffer_select_sel_inst (.clk(clk), .reset(reset), .awvalid(awvalid), .awready(),
    .awaddr(awaddr), .wvalid(wvalid), .wready(), .wdata(wdata), .wstrb(wstrb), .bvalid(), .bready(bready),
    .bresp(), .arvalid(arvalid), .arready(), .araddr(araddr), .rvalid(), .rready(rready), .rdata(), .rresp(),
    .refClockPinPosIn(posIn), .refClockPinPosOut(selPosOut), .refClockPinPosOeN(selPosOeN),
    .refClockPinNegIn(negIn), .refClockPinNegOut(selNegOut), .refClockPinNegOeN(selNegOeN),
    .recoveredRxClock(recClk), .recoveredClockChannelSelect(chSel), .pllRefClock(), .rowClockOut());
  rcbs_ref_clock_buffer_select #(.OUTPUT_MODE(1'h1), .SELECTABLE(1'h0), .FIXED_CHANNEL(2'h2))
    rcbs_ref_clock_buffer_select_fix_inst (.clk(clk), .reset(reset), .awvalid(awvalid), .awready(),
    .awaddr(awaddr), .wvalid(wvalid), .wready(), .wdata(wdata), .wstrb(wstrb), .bvalid(), .bready(bready),
    .bresp(), .arvalid(arvalid), .arready(), .araddr(araddr), .rvalid(), .rready(rready), .rdata(), .rresp(),
    .refClockPinPosIn(posIn), .refClockPinPosOut(fixPosOut), .refClockPinPosOeN(fixPosOeN),
    .refClockPinNegIn(negIn), .refClockPinNegOut(fixNegOut), .refClockPinNegOeN(fixNegOeN),
    .recoveredRxClock(recClk), .recoveredClockChannelSelect(chSel), .pllRefClock(), .rowClockOut());
  task close_out;
    $display("checks %0d errors %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      fails++;
      $display("Error %0t: no answer", $time);
      close_out();
    end
  endtask : tmo
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    tmo(n, 50);
    chk({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rready <= 1'h0;
    d = rdata;
    r = rresp;
    tmo(n, 50);
  endtask : axi_rd
  // rises of both clocks and high cycles of the row clock over 64 cycles
  task automatic sample(output int pr, output int rr, output int rh);
    logic pp, rp;
    pr = 0;
    rr = 0;
    rh = 0;
    repeat (8) @(posedge clk);
    pp = pllRefClock;
    rp = rowClockOut;
    repeat (64)
    begin
      @(posedge clk);
      if (pllRefClock === 1'h1 && pp === 1'h0) pr++;
      if (rowClockOut === 1'h1 && rp === 1'h0) rr++;
      if (rowClockOut === 1'h1) rh++;
      pp = pllRefClock;
      rp = rowClockOut;
    end
  endtask : sample
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    int pr, rr, rh;
    axi_rd(rcbs_pkg::ADDR_CTRL, d, r);
    chk(d, {24'h0, rcbs_pkg::CTRL_RESET});
    axi_rd(rcbs_pkg::ADDR_SIM, d, r);
    chk(d, {24'h0, rcbs_pkg::SIM_RESET});
    axi_rd(4'hc, d, r);
    chk({d[29:0], r}, {30'h0, rcbs_pkg::RESP_SLVERR});
    axi_wr(4'hc, 32'h0000000c, rcbs_pkg::RESP_SLVERR);
    axi_wr(rcbs_pkg::ADDR_STATUS, 32'hffffffff, rcbs_pkg::RESP_OKAY);
    sample(pr, rr, rh);
    chk(pr + rh, 0);
  endtask : t_reset
  task automatic t_rows;
    logic [31:0] d;
    logic [1:0] r;
    int pr, rr, rh;
    int er [4] = '{8, 4, 0, 0};
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(rcbs_pkg::ADDR_CTRL, {28'h0, i[1:0], 2'h2}, rcbs_pkg::RESP_OKAY);
      axi_rd(rcbs_pkg::ADDR_CTRL, d, r);
      chk(d, {28'h0, i[1:0], 2'h2});
      sample(pr, rr, rh);
      chk(pr, 8);
      chk(rr, er[i]);
      chk(rh, er[i] > 0 ? 32 : 0);
    end
    axi_wr(rcbs_pkg::ADDR_CTRL, 32'h00000007, rcbs_pkg::RESP_OKAY);
    sample(pr, rr, rh);
    chk(pr + rh, 0);
  endtask : t_rows
  task automatic t_seq;
    logic [31:0] d;
    logic [1:0] r;
    int n, t0;
    logic [8:0] len [4];
    // code 3 falls back to the approximated sequence
    len = '{rcbs_pkg::RESET_SEQ_APPROX, rcbs_pkg::RESET_SEQ_DETAILED, rcbs_pkg::RESET_SEQ_FAST_ALIGN,
      rcbs_pkg::RESET_SEQ_APPROX};
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(rcbs_pkg::ADDR_SIM, {30'h0, i[1:0]}, rcbs_pkg::RESP_OKAY);
      t0 = cyc;
      for (n = 0; n < 150; n++)
      begin
        axi_rd(rcbs_pkg::ADDR_STATUS, d, r);
        if (d[3] === 1'h1) break;
      end
      tmo(n, 150);
      chk(32'(cyc - t0 >= len[i] - 2 && cyc - t0 <= len[i] + 8), 32'h1);
    end
  endtask : t_seq
  task automatic t_detect;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    for (int p = 0; p < 2; p++)
    begin
      axi_wr(rcbs_pkg::ADDR_SIM, {28'h0, 1'h1, p[0], 2'h0}, rcbs_pkg::RESP_OKAY);
      for (n = 0; n < 50; n++)
      begin
        axi_rd(rcbs_pkg::ADDR_STATUS, d, r);
        if (d[4] === 1'h1) break;
      end
      tmo(n, 50);
      chk({30'h0, d[5], d[8]}, {30'h0, p[0], 1'h0});
    end
  endtask : t_detect
  // output mode: pins follow the chosen recovered clock three cycles late, off while powered down
  task automatic t_output;
    logic [3:0] hs, hf;
    int bad;
    bad = 0;
    hs = 4'h0;
    hf = 4'h0;
    @(posedge clk);
    chk({24'h0, posOut, negOut, selPosOut, selNegOut, fixPosOut, fixNegOut, posOeN, negOeN}, 32'h3);
    chk({28'h0, selPosOeN, selNegOeN, fixPosOeN, fixNegOeN}, 32'h0);
    axi_wr(rcbs_pkg::ADDR_CTRL, 32'h00000001, rcbs_pkg::RESP_OKAY);
    for (int k = 0; k < 260; k++)
    begin
      @(posedge clk);
      if (k >= 3 && {selPosOut, selNegOut, fixPosOut, fixNegOut} !== {hs[2], ~hs[2], hf[2], ~hf[2]})
        bad++;
      hs = {hs[2:0], recClk[chSel]};
      hf = {hf[2:0], recClk[2]};
    end
    chk(bad, 0);
    chk({30'h0, posOut, negOut}, 32'h0);
  endtask : t_output
  initial
  begin
    reset = 1'h1;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    t_reset();
    t_rows();
    t_seq();
    t_detect();
    t_output();
    close_out();
  end
endmodule : tb_ref_clock_buffer_select
